// >>> src/wake_pkg.sv
// Constants for the wake event and pattern register block
package wake_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'h68;
  localparam logic [7:0] ADDR_PATTERN = 8'h70;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h6c;
  localparam logic [7:0] ADDR_PM_CFG = 8'h74;
  // Wake control field positions
  localparam int BIT_LINK_FLAG = 0;
  localparam int BIT_MAGIC_FLAG = 1;
  localparam int BIT_FRAME_FLAG = 2;
  localparam int BIT_LINK_EN = 8;
  localparam int BIT_MAGIC_EN = 9;
  localparam int BIT_FRAME_EN = 10;
  localparam int BIT_SEED_SEL = 30;
  // Pattern area
  localparam int PAT_WORDS = 25;
  localparam int WORDS_PER_PAT = 5;
  localparam int PAT_COUNT = 5;
  localparam logic [4:0] PAT_LAST_IDX = 5'h18;
  localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;
  localparam logic [15:0] CRC_SEED_ONES = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [31:0] CTRL_WR_MASK = 32'h7e000700;
  localparam logic [2:0] FLAG_MASK = 3'h7;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Frame matcher states
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SCAN = 2'b01,
    M_DONE = 2'b11
  } match_state_t;
endpackage

// >>> src/wake_matcher.sv
// Pattern matcher: CRC16 over masked bytes, one engine per pattern
`timescale 1ns/1ps
module wake_matcher (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pattern store
  input wire logic [31:0] pattern_i [wake_pkg::PAT_WORDS],
  input wire logic [4:0] pat_enable_i,
  input wire logic crc_seed_select_i,
  // Receive byte stream
  input wire logic rx_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  // Result
  output logic match_o
);
  logic [15:0] crc_ff [wake_pkg::PAT_COUNT];
  logic [7:0] idx_ff;
  wake_pkg::match_state_t state_ff;
  logic match_ff;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ wake_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] seed(input logic s);
    return s ? wake_pkg::CRC_SEED_ONES : wake_pkg::CRC_SEED_ZERO;
  endfunction

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= wake_pkg::M_IDLE;
      idx_ff <= 8'h00;
    end else if (rx_start_i) begin
      state_ff <= wake_pkg::M_SCAN;
      idx_ff <= 8'h00;
    end else if (state_ff == wake_pkg::M_SCAN) begin
      if (rx_end_i) begin
        state_ff <= wake_pkg::M_DONE;
      end else if (rx_valid_i) begin
        idx_ff <= idx_ff + 8'h01;
      end
    end else if (state_ff == wake_pkg::M_DONE) begin
      state_ff <= wake_pkg::M_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int p = 0; p < wake_pkg::PAT_COUNT; p++) begin
      if (sys_rst_i || rx_start_i) begin
        crc_ff[p] <= seed(crc_seed_select_i);
      end else if (state_ff == wake_pkg::M_SCAN && rx_valid_i && !rx_end_i &&
                   idx_ff >= pattern_i[p*wake_pkg::WORDS_PER_PAT+4][7:0] &&
                   (idx_ff - pattern_i[p*wake_pkg::WORDS_PER_PAT+4][7:0]) < 8'h80 &&
                   pattern_i[p*wake_pkg::WORDS_PER_PAT + 32'((idx_ff - pattern_i[p*wake_pkg::WORDS_PER_PAT+4][7:0]) >> 5)]
                     [5'(idx_ff - pattern_i[p*wake_pkg::WORDS_PER_PAT+4][7:0])]) begin
        crc_ff[p] <= crc_step(crc_ff[p], rx_byte_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= 1'b0;
      if (state_ff == wake_pkg::M_DONE) begin
        for (int p = 0; p < wake_pkg::PAT_COUNT; p++) begin
          if (pat_enable_i[p] && crc_ff[p] == pattern_i[p*wake_pkg::WORDS_PER_PAT+4][31:16]) begin
            match_ff <= 1'b1;
          end
        end
      end
    end
  end

  assign match_o = match_ff;
endmodule

// >>> src/wake_regs.sv
// Wake event flags, enables, pattern area and AXI4-Lite slave
//
// Operation
// - With the magic enable set, a received magic packet raises the PM event status.
// - With the link-change enable set, a link change raises the PM event status; enable resets to 0.
// - A received wake-up frame sets the frame flag at bit 2.
// - A received magic packet sets the magic flag at bit 1.
// - A link status change sets the link flag at bit 0.
// - Each flag clears on a written one or power-up reset; a written zero keeps it.
// - Flags survive hardware and software resets; only power-up reset clears them.
// - Pattern 1 mask occupies pattern words 0 to 3, low bits first.
// - Word 4 holds pattern 1 CRC16 high, reserved byte, offset low byte.
// - Pattern 2 mask starts at word 5; each pattern takes five words.
// - CRC16 seed is 0000h when the type bit is 0, FFFFh when 1.
// - With the frame enable set, a matched wake-up frame raises the PM event status.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module wake_regs (
  // Clock and resets
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic por_i,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power-management strap
  input wire logic pm_wol_cfg_i,
  // Receive path
  input wire logic magic_rx_i,
  input wire logic link_change_i,
  input wire logic rx_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  // Status outputs
  output logic pm_event_status_o,
  output logic irq_o
);
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] ctrl_ff;
  logic [2:0] flag_ff;
  logic [2:0] irq_mask_ff;
  logic pm_event_status_ff;
  logic [31:0] pattern_ff [wake_pkg::PAT_WORDS];
  logic [4:0] pat_idx_ff;
  logic frame_match;
  logic do_write;
  logic [31:0] nxt_ctrl;
  logic [2:0] events;
  logic [2:0] clr_bits;
  logic wr_ctrl;
  logic rd_ctrl_ff;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    if (a == wake_pkg::ADDR_WAKE_CTRL) begin
      return 1'b1;
    end else if (a == wake_pkg::ADDR_PATTERN) begin
      return 1'b1;
    end else if (a == wake_pkg::ADDR_IRQ_MASK) begin
      return 1'b1;
    end else if (a == wake_pkg::ADDR_PM_CFG) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Write channels taken independently, answer after both
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ctrl = do_write && awaddr_ff == wake_pkg::ADDR_WAKE_CTRL;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= wake_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= known_addr(awaddr_ff) ? wake_pkg::RESP_OKAY : wake_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Control enables; reserved bits masked off
  assign nxt_ctrl = apply_strb(ctrl_ff, wdata_ff, wstrb_ff) & wake_pkg::CTRL_WR_MASK;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= 32'h00000000;
      ctrl_ff[wake_pkg::BIT_MAGIC_EN] <= pm_wol_cfg_i;
    end else if (wr_ctrl) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_mask_ff <= 3'h0;
    end else if (do_write && awaddr_ff == wake_pkg::ADDR_IRQ_MASK && wstrb_ff[0]) begin
      irq_mask_ff <= wdata_ff[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pat_idx_ff <= 5'h00;
    end else if (do_write && awaddr_ff == wake_pkg::ADDR_PATTERN) begin
      pat_idx_ff <= (pat_idx_ff == wake_pkg::PAT_LAST_IDX) ? 5'h00 : pat_idx_ff + 5'h01;
    end
  end

  // CRC word keeps reserved byte zero
  always_ff @(posedge clk_i) begin
    if (do_write && awaddr_ff == wake_pkg::ADDR_PATTERN) begin
      pattern_ff[pat_idx_ff] <= ((32'(pat_idx_ff) % wake_pkg::WORDS_PER_PAT) == 4) ?
        {wdata_ff[31:16], 8'h00, wdata_ff[7:0]} : wdata_ff;
    end
  end

  wake_matcher u_matcher (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pattern_i(pattern_ff),
    .pat_enable_i({ctrl_ff[25], ctrl_ff[26], ctrl_ff[27], ctrl_ff[28], ctrl_ff[29]}),
    .crc_seed_select_i(ctrl_ff[wake_pkg::BIT_SEED_SEL]),
    .rx_start_i(rx_start_i),
    .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i),
    .rx_end_i(rx_end_i),
    .match_o(frame_match)
  );

  assign events = {frame_match, magic_rx_i, link_change_i};
  assign clr_bits = wr_ctrl && wstrb_ff[0] ? wdata_ff[2:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      flag_ff <= 3'h0;
    end else begin
      flag_ff <= ((flag_ff & ~clr_bits) | events) & wake_pkg::FLAG_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      pm_event_status_ff <= 1'b0;
    end else if ((events[wake_pkg::BIT_MAGIC_FLAG] && ctrl_ff[wake_pkg::BIT_MAGIC_EN]) ||
                 (events[wake_pkg::BIT_LINK_FLAG] && ctrl_ff[wake_pkg::BIT_LINK_EN]) ||
                 (events[wake_pkg::BIT_FRAME_FLAG] && ctrl_ff[wake_pkg::BIT_FRAME_EN])) begin
      pm_event_status_ff <= 1'b1;
    end else if (do_write && awaddr_ff == wake_pkg::ADDR_PM_CFG && wstrb_ff[0] && wdata_ff[0]) begin
      pm_event_status_ff <= 1'b0;
    end
  end

  assign pm_event_status_o = pm_event_status_ff;
  assign irq_o = |(flag_ff & irq_mask_ff);

  // Read channel; one cycle latency
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= wake_pkg::RESP_OKAY;
      rd_ctrl_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= wake_pkg::RESP_OKAY;
      rd_ctrl_ff <= ({s_axi_araddr[7:2], 2'b00} == wake_pkg::ADDR_WAKE_CTRL);
      if ({s_axi_araddr[7:2], 2'b00} == wake_pkg::ADDR_WAKE_CTRL) begin
        rdata_ff <= ctrl_ff | {29'h0, flag_ff};
      end else if ({s_axi_araddr[7:2], 2'b00} == wake_pkg::ADDR_PATTERN) begin
        rdata_ff <= pattern_ff[pat_idx_ff];
      end else if ({s_axi_araddr[7:2], 2'b00} == wake_pkg::ADDR_IRQ_MASK) begin
        rdata_ff <= {29'h0, irq_mask_ff};
      end else if ({s_axi_araddr[7:2], 2'b00} == wake_pkg::ADDR_PM_CFG) begin
        rdata_ff <= {31'h0, pm_event_status_ff};
      end else begin
        rdata_ff <= 32'h00000000;
        rresp_ff <= wake_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  property p_link_flag;
    @(posedge clk_i) disable iff (por_i) link_change_i |=> flag_ff[0];
  endproperty
  a_link_flag: assert property (p_link_flag) else $error("link flag not set");

  property p_magic_flag;
    @(posedge clk_i) disable iff (por_i) magic_rx_i |=> flag_ff[1];
  endproperty
  a_magic_flag: assert property (p_magic_flag) else $error("magic flag not set");

  property p_frame_flag;
    @(posedge clk_i) disable iff (por_i) frame_match |=> flag_ff[2];
  endproperty
  a_frame_flag: assert property (p_frame_flag) else $error("frame flag not set");

  property p_w1c;
    @(posedge clk_i) disable iff (por_i) (|clr_bits) |=> (flag_ff & $past(clr_bits & ~events)) == 3'h0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_por_clear;
    @(posedge clk_i) por_i |=> flag_ff == 3'h0;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("flags not cleared by power-up reset");

  property p_hold;
    @(posedge clk_i) disable iff (por_i)
      (sys_rst_i && !wr_ctrl && |flag_ff) |=> (flag_ff & $past(flag_ff)) == $past(flag_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost on reset");

  property p_resv;
    @(posedge clk_i) disable iff (sys_rst_i) (s_axi_rvalid && rd_ctrl_ff) |-> (s_axi_rdata[7:3] == 5'h00);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits nonzero");

  property p_crc_resv;
    @(posedge clk_i) disable iff (sys_rst_i)
      (do_write && awaddr_ff == wake_pkg::ADDR_PATTERN && (32'(pat_idx_ff) % wake_pkg::WORDS_PER_PAT) == 4) |=>
      pattern_ff[$past(pat_idx_ff)][15:8] == 8'h00;
  endproperty
  a_crc_resv: assert property (p_crc_resv) else $error("reserved CRC byte nonzero");

  property p_magic_default;
    @(posedge clk_i) sys_rst_i |=> ctrl_ff[wake_pkg::BIT_MAGIC_EN] == $past(pm_wol_cfg_i);
  endproperty
  a_magic_default: assert property (p_magic_default) else $error("magic enable default wrong");

  property p_link_en_rst;
    @(posedge clk_i) sys_rst_i |=> !ctrl_ff[wake_pkg::BIT_LINK_EN];
  endproperty
  a_link_en_rst: assert property (p_link_en_rst) else $error("link enable not reset");

  property p_magic_pm;
    @(posedge clk_i) disable iff (por_i) (magic_rx_i && ctrl_ff[wake_pkg::BIT_MAGIC_EN]) |=> pm_event_status_o;
  endproperty
  a_magic_pm: assert property (p_magic_pm) else $error("magic did not raise PM");

  property p_link_pm;
    @(posedge clk_i) disable iff (por_i) (link_change_i && ctrl_ff[wake_pkg::BIT_LINK_EN]) |=> pm_event_status_o;
  endproperty
  a_link_pm: assert property (p_link_pm) else $error("link did not raise PM");

  property p_frame_pm;
    @(posedge clk_i) disable iff (por_i) (frame_match && ctrl_ff[wake_pkg::BIT_FRAME_EN]) |=> pm_event_status_o;
  endproperty
  a_frame_pm: assert property (p_frame_pm) else $error("frame did not raise PM");

  property p_idx_wrap;
    @(posedge clk_i) disable iff (sys_rst_i)
      (do_write && awaddr_ff == wake_pkg::ADDR_PATTERN && pat_idx_ff == wake_pkg::PAT_LAST_IDX) |=>
      pat_idx_ff == 5'h00;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("pattern index did not wrap");
endmodule

// >>> bench/rx_model.sv
// Receive path model: magic, link change and frame byte stream
`timescale 1ns/1ps
module rx_model (
  // Clock
  input wire logic clk_i,
  // Receive path
  output logic magic_o,
  output logic link_o,
  output logic start_o,
  output logic valid_o,
  output logic [7:0] byte_o,
  output logic end_o
);
  initial begin
    {magic_o, link_o, start_o, valid_o, end_o} = 5'h00;
    byte_o = 8'h5a;
  end
  task automatic magic();
    @(posedge clk_i);
    magic_o <= 1'b1;
    @(posedge clk_i);
    magic_o <= 1'b0;
  endtask
  task automatic link();
    @(posedge clk_i);
    link_o <= 1'b1;
    @(posedge clk_i);
    link_o <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] f [8]);
    @(posedge clk_i);
    start_o <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      start_o <= 1'b0;
      valid_o <= 1'b1;
      byte_o <= f[i];
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    end_o <= 1'b1;
    // Idle line never repeats the last byte
    byte_o <= ~f[7];
    @(posedge clk_i);
    end_o <= 1'b0;
  endtask
endmodule

// >>> bench/testbench.sv
// Testbench for the wake register block
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, por_i = 1'b1, pm_wol_cfg_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_byte_i;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic magic_rx_i, link_change_i, rx_start_i, rx_valid_i, rx_end_i, pm_event_status_o, irq_o;
  logic [31:0] pat [25];
  logic [7:0] frm [8];
  logic [15:0] crc;
  int miscompares = 0, compares = 0, cycles = 0;

  wake_regs DUT (.clk_i, .sys_rst_i, .por_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pm_wol_cfg_i, .magic_rx_i, .link_change_i, .rx_start_i,
    .rx_valid_i, .rx_byte_i, .rx_end_i, .pm_event_status_o, .irq_o);
  rx_model rx (.clk_i, .magic_o(magic_rx_i), .link_o(link_change_i), .start_o(rx_start_i),
    .valid_o(rx_valid_i), .byte_o(rx_byte_i), .end_o(rx_end_i));

  always #12.5 clk_i = ~clk_i;

  // Hang guard, far above the expected run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    chk(rd_data, exp);
  endtask

  task automatic rst_pulse(input logic p);
    @(posedge clk_i);
    sys_rst_i <= ~p;
    por_i <= p;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    por_i <= 1'b0;
  endtask

  task automatic load(input int n);
    for (int k = 0; k < n; k++) wr(wake_pkg::ADDR_PATTERN, pat[k]);
  endtask

  task automatic pmchk(input logic exp);
    chk({31'h0, pm_event_status_o}, {31'h0, exp});
  endtask

  // Masked CRC over frame bytes 0..3, bit 0 of each byte first
  function automatic logic [15:0] crc16(input logic [15:0] s);
    logic [15:0] c;
    logic fb;
    c = s;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 8; j++) begin
        fb = c[15] ^ frm[i][j];
        c = {c[14:0], 1'b0};
        if (fb) c = c ^ wake_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction

  initial begin
    frm = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
    crc = crc16(16'h0000);
    foreach (pat[k]) pat[k] = 32'h0;
    pat[0] = 32'hdeadbeef;
    pat[4] = 32'h1234ab00;
    pat[5] = 32'h0000000f;
    pat[9] = {crc, 16'h0000};
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    por_i <= 1'b0;
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000200);
    rdc(8'h00, 32'h0);
    chk({30'h0, resp}, {30'h0, wake_pkg::RESP_SLVERR});
    wr(8'h00, 32'hffffffff);
    chk({30'h0, resp}, {30'h0, wake_pkg::RESP_SLVERR});
    wr(wake_pkg::ADDR_WAKE_CTRL, 32'h000002f8);
    chk({30'h0, resp}, {30'h0, wake_pkg::RESP_OKAY});
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000200);
    rx.magic();
    @(posedge clk_i);
    pmchk(1'b1);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000202);
    chk({31'h0, irq_o}, 32'h0);
    wr(wake_pkg::ADDR_IRQ_MASK, 32'h00000002);
    chk({31'h0, irq_o}, 32'h1);
    wr(wake_pkg::ADDR_PM_CFG, 32'h00000001);
    pmchk(1'b0);
    rx.link();
    @(posedge clk_i);
    pmchk(1'b0);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000203);
    wr(wake_pkg::ADDR_WAKE_CTRL, 32'h00000300);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000303);
    rx.link();
    @(posedge clk_i);
    pmchk(1'b1);
    wr(wake_pkg::ADDR_WAKE_CTRL, 32'h00000302);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000301);
    chk({31'h0, irq_o}, 32'h0);
    pm_wol_cfg_i <= 1'b0;
    rst_pulse(1'b0);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h00000001);
    pmchk(1'b1);
    rst_pulse(1'b1);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h0);
    pmchk(1'b0);
    load(25);
    rdc(wake_pkg::ADDR_PATTERN, 32'hdeadbeef);
    rst_pulse(1'b0);
    load(4);
    rdc(wake_pkg::ADDR_PATTERN, 32'h12340000);
    rst_pulse(1'b0);
    load(25);
    wr(wake_pkg::ADDR_WAKE_CTRL, 32'h10000400);
    rx.frame(frm);
    repeat (4) @(posedge clk_i);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h10000404);
    pmchk(1'b1);
    wr(wake_pkg::ADDR_WAKE_CTRL, 32'h50000404);
    wr(wake_pkg::ADDR_PM_CFG, 32'h00000001);
    rx.frame(frm);
    repeat (4) @(posedge clk_i);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h50000400);
    pmchk(1'b0);
    crc = crc16(16'hffff);
    pat[9] = {crc, 16'h0000};
    rst_pulse(1'b0);
    load(25);
    wr(wake_pkg::ADDR_WAKE_CTRL, 32'h50000400);
    rx.frame(frm);
    repeat (4) @(posedge clk_i);
    rdc(wake_pkg::ADDR_WAKE_CTRL, 32'h50000404);
    pmchk(1'b1);
    wrap_up();
  end
endmodule
